// *** lcl_pkg.sv ***
package lcl_pkg;

   // ************************************************
   // Timing
   // ************************************************
   localparam int          CLK_PERIOD_NS  = 20;
   localparam int          STEP_NS        = 320;
   localparam int          STEP_CYC       = STEP_NS / CLK_PERIOD_NS;
   localparam logic [7:0]  STEP_LAST      = 8'(STEP_CYC - 1);

   // ************************************************
   // Select register layout and register codes
   // ************************************************
   localparam int          SEL_REG_LSB    = 6;
   localparam int          SEL_BANK_LSB   = 10;
   localparam int          SEL_HALF_BIT   = 13;
   localparam int          SEL_CLRINT_BIT = 15;
   localparam int          LINE_ADDR_LSB  = 0;
   localparam logic [3:0]  REG_TX         = 4'h0;
   localparam logic [3:0]  REG_AVAIL      = 4'h1;
   localparam logic [3:0]  REG_IRQ        = 4'h2;
   localparam logic [3:0]  REG_MASK       = 4'h3;
   localparam logic [3:0]  REG_LINE       = 4'h4;
   localparam logic [2:0]  BANK_STD       = 3'h0;
   localparam logic [15:0] UNIT_ONE       = 16'h0001;

   // ************************************************
   // Microword fields and codes
   // ************************************************
   localparam logic [1:0]  STB_NONE       = 2'h0;
   localparam logic [1:0]  STB_WR         = 2'h1;
   localparam logic [1:0]  STB_RD         = 2'h2;
   localparam logic [1:0]  SCAN_NONE      = 2'h0;
   localparam logic [1:0]  SCAN_ACK       = 2'h1;
   localparam logic [1:0]  SCAN_HALF      = 2'h2;
   localparam logic [3:0]  DLY_REPLY      = 4'hF;
   localparam logic [3:0]  DLY_NONE       = 4'h0;
   localparam logic [7:0]  UA_WRITE       = 8'h00;
   localparam logic [7:0]  UA_WR_GAP      = 8'h01;
   localparam logic [7:0]  UA_WR_HI       = 8'h02;
   localparam logic [7:0]  UA_WR_END      = 8'h03;
   localparam logic [7:0]  UA_READ        = 8'h10;
   localparam logic [7:0]  UA_RD_GAP      = 8'h11;
   localparam logic [7:0]  UA_RD_HI       = 8'h12;
   localparam logic [7:0]  UA_RD_END      = 8'h13;
   localparam logic [7:0]  UA_FAIL        = 8'h1F;

   typedef struct packed {
      logic       par;
      logic [1:0] strobe;
      logic [3:0] delay;
      logic [1:0] scan;
      logic       bren;
      logic       hi_byte;
      logic       done;
      logic [7:0] target;
   } lcl_uword_t;

   typedef enum logic [1:0] {HS_IDLE, HS_RUN, HS_SYNC} lcl_hs_t;

   typedef struct packed {
      logic        active;
      logic [10:0] pc;
      logic [7:0]  timer;
   } lcl_seq_t;

   typedef struct packed {
      lcl_hs_t           hs;
      logic [15:0]       sel;
      logic [15:0]       line;
      logic [15:0]       mask;
      logic [15:0]       flags;
      logic [15:0]       tx;
      logic [15:0]       avail;
      logic [17:0]       hold;
      logic [17:0]       rdata;
      logic [15:0]       info_out;
      logic [1:0]        info_par;
      logic              info_oe;
      logic              op_read;
      logic              ack_res;
      logic              ack_prev;
      logic              err;
      logic              mismatch;
      logic [8:0]        dbo;
      lcl_seq_t [1:0]    seq;
   } lcl_state_t;

   // Microcode store, one bank populated, even parity over the word
   function automatic lcl_uword_t lcl_rom(input logic [10:0] a);
      lcl_uword_t w;
      w = '{1'b0, STB_NONE, DLY_NONE, SCAN_NONE, 1'b0, 1'b0, 1'b1, UA_WRITE};
      if (a[10:8] == BANK_STD) begin
         case (a[7:0])
            UA_WRITE:  w = '{1'b0, STB_WR, DLY_REPLY, SCAN_ACK, 1'b1, 1'b0, 1'b0, UA_FAIL};
            UA_WR_GAP: w = '{1'b0, STB_NONE, DLY_NONE, SCAN_HALF, 1'b1, 1'b0, 1'b0, UA_WR_END};
            UA_WR_HI:  w = '{1'b0, STB_WR, DLY_REPLY, SCAN_ACK, 1'b1, 1'b1, 1'b0, UA_FAIL};
            UA_READ:   w = '{1'b0, STB_RD, DLY_REPLY, SCAN_ACK, 1'b1, 1'b0, 1'b0, UA_FAIL};
            UA_RD_GAP: w = '{1'b0, STB_NONE, DLY_NONE, SCAN_HALF, 1'b1, 1'b0, 1'b0, UA_RD_END};
            UA_RD_HI:  w = '{1'b0, STB_RD, DLY_REPLY, SCAN_ACK, 1'b1, 1'b1, 1'b0, UA_FAIL};
            default:   w = w;
         endcase
      end
      w.par = ^w[18:0];
      return w;
   endfunction : lcl_rom

   // Step length: one nominal step, or delay+1 steps when scanning for the reply
   function automatic logic [7:0] lcl_step_load(input lcl_uword_t w);
      if (w.scan == SCAN_ACK) begin
         return 8'((int'(w.delay) + 1) * STEP_CYC - 1);
      end
      return STEP_LAST;
   endfunction : lcl_step_load

endpackage : lcl_pkg

// *** lcl_line_side.sv ***
`timescale 1ns/1ps
// Operation
// - Four sixteen-bit registers, one bit per unit
// - Units drive activity bits; only orders clear interrupts
// - Transmit bit follows unit transmission start
// - Data-available bit follows receive half-full
// - Masked interrupt bits ORed onto request line
// - Data request returns interrupt register contents
// - Interrupts cleared only by dedicated command order
// - Data-present order loads interrupt mask register
// - Mask bit one enables, zero suppresses
// - Command selects register, request reads it
// - Host word split into two bytes, rejoined
// - Low parity with first byte, high with second
// - Inbound byte parity placed mirroring outbound
// - Missing unit acknowledgment flags failure
// - Half-word mode uses low byte only
// - Microinstruction step lasts 320 ns
// - Duplicated sequencer, mismatch flags fault
// - Microword twenty bits, 256 deep, parity checked
// - Microcode banks chosen by select register
// - Unit command loads start address by type
// - Each step increments or branches on scan
// - Race stage aligns reply for both copies
// - Reply ends programmed delay immediately
// - Data request drives data onto information leads
// - Controller command overwrites whole select register
module lcl_line_side
   import lcl_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Host order strobes and address decode
   input  wire logic        ctl_addressed,
   input  wire logic        unit_addressed,
   input  wire logic        command_present_strobe,
   input  wire logic        data_present_strobe,
   input  wire logic        data_request_strobe,
   // Host information leads
   input  wire logic [15:0] info_in,
   input  wire logic [1:0]  info_par_in,
   output logic      [15:0] info_out,
   output logic      [1:0]  info_par_out,
   output logic             info_oe,
   // Host responses
   output logic             sync,
   output logic             err_flag,
   output logic             interrupt_request_line,
   // Unit data bus
   output logic      [15:0] unit_enable,
   output logic             unit_write_strobe,
   output logic             unit_read_strobe,
   output logic      [8:0]  unit_data_bus_out,
   output logic             unit_data_bus_oe,
   input  wire logic [8:0]  unit_data_bus_in,
   input  wire logic        unit_ack,
   // Unit activity inputs
   input  wire logic [15:0] unit_tx_active,
   input  wire logic [15:0] unit_rx_half_full,
   input  wire logic [15:0] unit_irq_set,
   // Sequencer health
   output logic             seq_mismatch,
   output logic             rom_parity_err
);

   // ************************************************
   // State and helpers
   // ************************************************
   lcl_state_t       s;
   lcl_state_t       n;
   lcl_uword_t [1:0] uw;
   logic             any_strobe;
   logic             ack_seen;
   logic             half_mode;
   logic             clr_order;
   logic [3:0]       reg_code;
   logic [2:0]       bank;

   assign any_strobe = command_present_strobe | data_present_strobe | data_request_strobe;
   assign ack_seen   = s.ack_res & ~s.ack_prev;
   assign half_mode  = s.sel[SEL_HALF_BIT];
   assign reg_code   = s.sel[SEL_REG_LSB +: 4];
   assign bank       = s.sel[SEL_BANK_LSB +: 3];
   assign clr_order  = (s.hs == HS_IDLE) & ctl_addressed & command_present_strobe
                       & info_in[SEL_CLRINT_BIT];

   // Microcode lookup for each sequencer copy
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_rom
         assign uw[g] = lcl_rom(s.seq[g].pc);
      end
   endgenerate

   // ************************************************
   // Next-state logic
   // ************************************************
   always_comb begin
      logic [1:0]  step_end;
      logic [1:0]  cond;
      logic [10:0] npc;
      lcl_uword_t  nw;
      step_end = '0;
      cond     = '0;
      npc      = '0;
      nw       = '0;
      n        = s;

      // Race stage and activity sampling
      n.ack_res  = unit_ack;
      n.ack_prev = s.ack_res;
      n.tx       = unit_tx_active;
      n.avail    = unit_rx_half_full;
      n.mismatch = (s.seq[0] != s.seq[1]);

      // Interrupt flags: set beats a same-cycle clear
      if (clr_order) begin
         n.flags = unit_irq_set;
      end else begin
         n.flags = s.flags | unit_irq_set;
      end

      // Sequencer copies
      for (int i = 0; i < 2; i++) begin
         if (s.seq[i].active) begin
            step_end[i] = (s.seq[i].timer == '0)
                          | ((uw[i].scan == SCAN_ACK) & ack_seen);
            cond[i]     = ((uw[i].scan == SCAN_ACK) & ~ack_seen)
                          | ((uw[i].scan == SCAN_HALF) & half_mode);
            if (step_end[i]) begin
               if (uw[i].done) begin
                  n.seq[i].active = 1'b0;
               end else begin
                  if (uw[i].bren & cond[i]) begin
                     npc = {bank, uw[i].target};
                  end else begin
                     npc = 11'(s.seq[i].pc + 11'h001);
                  end
                  n.seq[i].pc    = npc;
                  n.seq[i].timer = lcl_step_load(lcl_rom(npc));
               end
            end else begin
               n.seq[i].timer = 8'(s.seq[i].timer - 8'h01);
            end
         end
      end

      // Inbound byte capture into the joined word
      if (step_end[0] & (uw[0].strobe == STB_RD) & ack_seen) begin
         if (uw[0].hi_byte) begin
            n.rdata[15:8] = unit_data_bus_in[7:0];
            n.rdata[17]   = unit_data_bus_in[8];
         end else begin
            n.rdata[7:0]  = unit_data_bus_in[7:0];
            n.rdata[16]   = unit_data_bus_in[8];
         end
      end

      // Fault capture: missing reply, bad microword, copies apart
      if (s.seq[0].active & step_end[0] & ~uw[0].done & uw[0].bren & cond[0]
          & (uw[0].target == UA_FAIL)) begin
         n.err = 1'b1;
      end
      if (s.seq[0].active & (^uw[0])) begin
         n.err = 1'b1;
      end
      if (s.mismatch) begin
         n.err = 1'b1;
      end

      // Host order handshake
      case (s.hs)
         HS_IDLE: begin
            n.info_oe = 1'b0;
            if (ctl_addressed & any_strobe) begin
               n.hs  = HS_SYNC;
               n.err = 1'b0;
               if (command_present_strobe) begin
                  n.sel = info_in;
               end else if (data_present_strobe) begin
                  if (reg_code == REG_MASK) begin
                     n.mask = info_in;
                  end else if (reg_code == REG_LINE) begin
                     n.line = info_in;
                  end
               end else begin
                  n.info_oe  = 1'b1;
                  n.info_par = '0;
                  case (reg_code)
                     REG_TX:    n.info_out = s.tx;
                     REG_AVAIL: n.info_out = s.avail;
                     REG_IRQ:   n.info_out = s.flags;
                     REG_MASK:  n.info_out = s.mask;
                     REG_LINE:  n.info_out = s.line;
                     default:   n.info_out = '0;
                  endcase
               end
            end else if (unit_addressed & (data_present_strobe | data_request_strobe)) begin
               n.hs      = HS_RUN;
               n.err     = 1'b0;
               n.op_read = data_request_strobe;
               n.hold    = {info_par_in, info_in};
               n.rdata   = '0;
               for (int i = 0; i < 2; i++) begin
                  n.seq[i].active = 1'b1;
                  n.seq[i].pc     = {bank, data_request_strobe ? UA_READ : UA_WRITE};
                  n.seq[i].timer  = lcl_step_load(lcl_rom(n.seq[i].pc));
               end
            end else if (unit_addressed & command_present_strobe) begin
               n.hs = HS_SYNC;
            end
         end
         HS_RUN: begin
            if (~s.seq[0].active) begin
               n.hs = HS_SYNC;
               if (s.op_read) begin
                  n.info_oe  = 1'b1;
                  n.info_out = s.rdata[15:0];
                  n.info_par = s.rdata[17:16];
               end
            end
         end
         HS_SYNC: begin
            if (~any_strobe) begin
               n.hs      = HS_IDLE;
               n.info_oe = 1'b0;
            end
         end
         default: begin
            n.hs = HS_IDLE;
         end
      endcase

      // Outbound byte with its parity for the coming step
      nw    = lcl_rom(n.seq[0].pc);
      n.dbo = nw.hi_byte ? {n.hold[17], n.hold[15:8]} : {n.hold[16], n.hold[7:0]};
   end

   // ************************************************
   // State register
   // ************************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   // ************************************************
   // Outputs
   // ************************************************
   assign info_out               = s.info_out;
   assign info_par_out           = s.info_par;
   assign info_oe                = s.info_oe;
   assign sync                   = (s.hs == HS_SYNC);
   assign err_flag               = s.err;
   assign interrupt_request_line = |(s.flags & s.mask);
   assign unit_enable            = s.seq[0].active ? (UNIT_ONE << s.line[LINE_ADDR_LSB +: 4]) : '0;
   assign unit_write_strobe      = s.seq[0].active & (uw[0].strobe == STB_WR);
   assign unit_read_strobe       = s.seq[0].active & (uw[0].strobe == STB_RD);
   assign unit_data_bus_out      = s.dbo;
   assign unit_data_bus_oe       = unit_write_strobe;
   assign seq_mismatch           = s.mismatch;
   assign rom_parity_err         = s.seq[0].active & (^uw[0]);

   // ************************************************
   // Assertions
   // ************************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   sequence ctl_read_s;
      (s.hs == HS_IDLE) && ctl_addressed && !command_present_strobe
      && !data_present_strobe && data_request_strobe;
   endsequence

   sequence plain_step_s;
      s.seq[0].active && (s.seq[0].timer == STEP_LAST) && (uw[0].scan == SCAN_NONE);
   endsequence

   irq_raise_a: assert property (
      ((unit_irq_set & s.mask) != '0) |=> interrupt_request_line)
      else $error("masked unit interrupt did not raise request line");

   irq_hold_a: assert property (
      !clr_order |=> (($past(s.flags) & ~s.flags) == '0))
      else $error("interrupt flag dropped without clear order");

   mask_load_a: assert property (
      ((s.hs == HS_IDLE) && ctl_addressed && !command_present_strobe && data_present_strobe
       && (reg_code == REG_MASK)) |=> (s.mask == $past(info_in)))
      else $error("mask register not loaded from data-present order");

   select_load_a: assert property (
      ((s.hs == HS_IDLE) && ctl_addressed && command_present_strobe)
      |=> (s.sel == $past(info_in)) && sync)
      else $error("select register not overwritten by command order");

   irq_read_a: assert property (
      (ctl_read_s and (reg_code == REG_IRQ)) |=> (info_out == $past(s.flags)) && info_oe && sync)
      else $error("interrupt register not returned on data request");

   tx_track_a: assert property (
      (unit_tx_active != '0) |=> ((s.tx & $past(unit_tx_active)) == $past(unit_tx_active)))
      else $error("transmit bit not set while unit transmits");

   step_time_a: assert property (
      plain_step_s |-> ##15 (s.seq[0].timer == '0))
      else $error("plain step does not last sixteen cycles");

   reply_end_a: assert property (
      (s.seq[0].active && (uw[0].scan == SCAN_ACK) && ack_seen)
      |=> (s.seq[0].pc != $past(s.seq[0].pc)) || !s.seq[0].active)
      else $error("reply did not end the step at once");

   copy_match_a: assert property (
      (s.seq[0] != s.seq[1]) |=> seq_mismatch ##1 err_flag)
      else $error("sequencer copies apart without fault");

   half_low_a: assert property (
      (half_mode && unit_write_strobe) |-> !uw[0].hi_byte)
      else $error("high byte sent in half-word mode");

   first_par_a: assert property (
      (unit_write_strobe && !uw[0].hi_byte) |-> (unit_data_bus_out[8] == s.hold[16]))
      else $error("first byte lacks low parity bit");

   no_ack_a: assert property (
      (s.seq[0].active && (uw[0].scan == SCAN_ACK) && uw[0].bren && (s.seq[0].timer == '0)
       && !ack_seen && !uw[0].done) |=> ##1 err_flag)
      else $error("missing acknowledgment not flagged");

endmodule : lcl_line_side

// *** lcl_unit_model.sv ***
`timescale 1ns/1ps
// ****
// Line interface unit model
// ****
module lcl_unit_model
   import lcl_pkg::*;
#(
   parameter int ID = 3
)
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Unit data bus to and from the controller
   input  wire logic [15:0] unit_enable,
   input  wire logic        unit_write_strobe,
   input  wire logic        unit_read_strobe,
   input  wire logic [8:0]  unit_data_bus_out,
   output logic      [8:0]  unit_data_bus_in,
   output logic             unit_ack,
   // Test controls and captured bytes
   input  wire logic [7:0]  reply_delay,
   input  wire logic [15:0] read_word,
   output logic      [17:0] written
);
   logic [7:0] cnt_reg;
   logic       idx_reg;
   logic [8:0] last_reg;
   logic [7:0] rbyte;
   logic       sel;
   logic       par_ok;

   // Selection, byte order and parity test
   assign sel    = unit_enable[ID];
   assign rbyte  = idx_reg ? read_word[15:8] : read_word[7:0];
   assign par_ok = unit_data_bus_out[8] == ^unit_data_bus_out[7:0];
   // Read byte with generated parity, else a pattern that changes each cycle
   assign unit_data_bus_in = (sel && unit_read_strobe) ? {^rbyte, rbyte} : ~last_reg;

   // Reply after a programmable delay, only to good bytes
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg  <= 8'h00;
         idx_reg  <= 1'b0;
         last_reg <= 9'h000;
         unit_ack <= 1'b0;
         written  <= 18'h00000;
      end else begin
         last_reg <= unit_data_bus_in;
         if (!sel || !(unit_write_strobe || unit_read_strobe)) begin
            cnt_reg  <= 8'h00;
            unit_ack <= 1'b0;
            if (unit_ack) begin
               idx_reg <= !idx_reg;
            end
            if (unit_enable == 16'h0000) begin
               idx_reg <= 1'b0;
            end
         end else if (cnt_reg < reply_delay) begin
            cnt_reg <= cnt_reg + 8'h01;
         end else if (unit_read_strobe || par_ok) begin
            unit_ack <= 1'b1;
            if (unit_write_strobe && idx_reg) begin
               written[17:9] <= unit_data_bus_out;
            end else if (unit_write_strobe) begin
               written[8:0] <= unit_data_bus_out;
            end
         end
      end
   end
endmodule : lcl_unit_model

// *** lcl_line_side_test.sv ***
`timescale 1ns/1ps
// ****
// Testbench
// ****
module lcl_line_side_test;
   import lcl_pkg::*;
   typedef struct packed {
      logic [7:0]  dly;
      logic [15:0] word;
      logic [15:0] tx;
      logic [15:0] av;
   } lcl_row_t;
   logic clk, rst_n, ctl_addressed, unit_addressed, sync, err_flag, interrupt_request_line, info_oe;
   logic command_present_strobe, data_present_strobe, data_request_strobe, unit_ack;
   logic unit_write_strobe, unit_read_strobe, unit_data_bus_oe, seq_mismatch, rom_parity_err, er, oe;
   logic [15:0] info_in, info_out, unit_enable, unit_tx_active, unit_rx_half_full, unit_irq_set, read_word;
   logic [1:0]  info_par_in, info_par_out;
   logic [8:0]  unit_data_bus_out, unit_data_bus_in;
   logic [7:0]  reply_delay;
   logic [17:0] rd, written;
   int          mismatches, total_checks;
   lcl_row_t    rows [3];

   lcl_line_side i_dut (.clk(clk), .rst_n(rst_n), .ctl_addressed(ctl_addressed),
      .unit_addressed(unit_addressed), .command_present_strobe(command_present_strobe),
      .data_present_strobe(data_present_strobe), .data_request_strobe(data_request_strobe),
      .info_in(info_in), .info_par_in(info_par_in), .info_out(info_out), .info_par_out(info_par_out),
      .info_oe(info_oe), .sync(sync), .err_flag(err_flag), .interrupt_request_line(interrupt_request_line),
      .unit_enable(unit_enable), .unit_write_strobe(unit_write_strobe), .unit_read_strobe(unit_read_strobe),
      .unit_data_bus_out(unit_data_bus_out), .unit_data_bus_oe(unit_data_bus_oe),
      .unit_data_bus_in(unit_data_bus_in), .unit_ack(unit_ack), .unit_tx_active(unit_tx_active),
      .unit_rx_half_full(unit_rx_half_full), .unit_irq_set(unit_irq_set), .seq_mismatch(seq_mismatch),
      .rom_parity_err(rom_parity_err));

   lcl_unit_model #(.ID(3)) i_unit (.clk(clk), .rst_n(rst_n), .unit_enable(unit_enable),
      .unit_write_strobe(unit_write_strobe), .unit_read_strobe(unit_read_strobe),
      .unit_data_bus_out(unit_data_bus_out), .unit_data_bus_in(unit_data_bus_in), .unit_ack(unit_ack),
      .reply_delay(reply_delay), .read_word(read_word), .written(written));

   // Clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // Even parity of each byte, high byte first
   function automatic logic [1:0] par2(input logic [15:0] d);
      return {^d[15:8], ^d[7:0]};
   endfunction : par2

   // Compare and count
   task automatic check(input logic [17:0] seen, input logic [17:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // One host order: hold strobe until sync, then release
   task automatic order(input logic ctl, input int k, input logic [15:0] d, input logic [1:0] p);
      int n;
      @(negedge clk);
      ctl_addressed = ctl;
      unit_addressed = !ctl;
      command_present_strobe = (k == 0);
      data_present_strobe = (k == 1);
      data_request_strobe = (k == 2);
      info_in = d;
      info_par_in = p;
      n = 0;
      while (sync !== 1'b1 && n < 2000) begin
         @(negedge clk);
         n++;
      end
      check(18'(n < 2000), 18'h00001);
      rd = {info_par_out, info_out};
      er = err_flag;
      oe = info_oe;
      @(negedge clk);
      {ctl_addressed, unit_addressed, command_present_strobe, data_present_strobe, data_request_strobe} = 5'h00;
      n = 0;
      while (sync !== 1'b0 && n < 10) begin
         @(negedge clk);
         n++;
      end
   endtask : order

   // Controller register write and read through the select register
   task automatic wreg(input logic [3:0] c, input logic [15:0] v);
      order(1'b1, 0, 16'(c) << 6, 2'h0);
      order(1'b1, 1, v, par2(v));
   endtask : wreg

   task automatic rreg(input logic [3:0] c, input logic [15:0] v);
      order(1'b1, 0, 16'(c) << 6, 2'h0);
      order(1'b1, 2, 16'h0000, 2'h0);
      check({17'h00000, oe}, 18'h00001);
      check(rd, {2'h0, v});
   endtask : rreg

   // Verdict
   task automatic print_verdict;
      $display("checks=%0d mismatches=%0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : print_verdict

   // Watchdog
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      print_verdict();
   end

   // Main sequence
   initial begin
      rows[0] = '{8'h00, 16'hA55A, 16'h8001, 16'h0000};
      rows[1] = '{8'h09, 16'h0000, 16'h0000, 16'hFFFF};
      rows[2] = '{8'h2F, 16'hFFFF, 16'h1234, 16'h4321};
      {rst_n, ctl_addressed, unit_addressed, command_present_strobe, data_present_strobe} = 5'h00;
      {data_request_strobe, info_in, info_par_in, unit_tx_active, unit_rx_half_full} = 51'h0;
      {unit_irq_set, read_word, reply_delay} = 40'h0;
      repeat (20) @(negedge clk);
      rst_n = 1'b1;
      rreg(REG_MASK, 16'h0000);
      wreg(REG_LINE, 16'h0003);
      foreach (rows[i]) begin
         reply_delay = rows[i].dly;
         unit_tx_active = rows[i].tx;
         unit_rx_half_full = rows[i].av;
         read_word = ~rows[i].word;
         order(1'b0, 1, rows[i].word, par2(rows[i].word));
         check({16'h0000, er, 1'b0}, 18'h00000);
         check(written, {^rows[i].word[15:8], rows[i].word[15:8], ^rows[i].word[7:0], rows[i].word[7:0]});
         check({16'h0000, seq_mismatch, rom_parity_err}, 18'h00000);
         order(1'b0, 2, 16'h0000, 2'h0);
         check(rd, {par2(~rows[i].word), ~rows[i].word});
         rreg(REG_TX, rows[i].tx);
         rreg(REG_AVAIL, rows[i].av);
      end
      // Interrupt set, mask, read and clear
      wreg(REG_MASK, 16'h0000);
      @(negedge clk);
      unit_irq_set = 16'h0020;
      @(negedge clk);
      unit_irq_set = 16'h0000;
      repeat (2) @(negedge clk);
      check({17'h00000, interrupt_request_line}, 18'h00000);
      rreg(REG_IRQ, 16'h0020);
      wreg(REG_MASK, 16'h0020);
      check({17'h00000, interrupt_request_line}, 18'h00001);
      wreg(REG_MASK, 16'hFFDF);
      check({17'h00000, interrupt_request_line}, 18'h00000);
      rreg(REG_IRQ, 16'h0020);
      order(1'b1, 0, 16'h8000, 2'h0);
      rreg(REG_IRQ, 16'h0000);
      // Half-word mode uses the low byte only
      order(1'b1, 0, 16'h2000, 2'h0);
      read_word = 16'hC381;
      order(1'b0, 2, 16'h0000, 2'h0);
      check(rd, {1'b0, ^8'h81, 16'h0081});
      order(1'b0, 1, 16'hBEEF, par2(16'hBEEF));
      check(written, {^8'hFF, 8'hFF, ^8'hEF, 8'hEF});
      // Bad parity and an unselected unit both go unanswered
      order(1'b1, 0, 16'h0000, 2'h0);
      order(1'b0, 1, 16'h1234, ~par2(16'h1234));
      check({17'h00000, er}, 18'h00001);
      wreg(REG_LINE, 16'h0002);
      order(1'b0, 1, 16'h1234, par2(16'h1234));
      check({17'h00000, er}, 18'h00001);
      // Reset while idle clears mask and flags
      wreg(REG_MASK, 16'h00FF);
      unit_irq_set = 16'h0001;
      @(negedge clk);
      unit_irq_set = 16'h0000;
      check({17'h00000, interrupt_request_line}, 18'h00001);
      rst_n = 1'b0;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      check({17'h00000, interrupt_request_line}, 18'h00000);
      check({unit_enable, sync, err_flag}, 18'h00000);
      rreg(REG_MASK, 16'h0000);
      rreg(REG_IRQ, 16'h0000);
      print_verdict();
   end
endmodule : lcl_line_side_test
